// ---- hdl/dxwm_map.v ----
// dsp x-memory register window mapper with shared dsp2/dsp3 data area
// assumes the register fabric answers a read in the cycle after dev_rd
// and the firmware memories answer fw_rdata in the cycle of fw_rd
//
// Function
// [R01] host firmware access needs no dsp clock
// [R02] both shared ranges reach same storage
// [R03] simultaneous dsp writes capture collision word address
// [R04] collision raises an interrupt event
// [R05] two program words per three registers
// [R06] x-memory reaches every device register
// [R07] windows same address, outside core data
// [R08] fixed window maps one-to-one from zero
// [R09] four movable 1024-address windows
// [R10] each window has its own page
// [R11] halfword mode: one 16-bit register each
// [R12] wide mode: register pair each address
// [R13] wide mode transfers only low 24 bits
// [R14] page value scaled by 512
// [R15] window bases fully independent
// [R16] firmware touches low registers only with clock
// [R17] dsp1 program memory 8k words
// [R18] dsp2/dsp3 program memory 20k words
// [R19] dsp4 program memory 12k words
// [R20] dsp6 x data memory 40k words
// [R21] dsp1 x data memory 16k words
// [R22] dsp3 x data memory 36k words
// [R23] control word bit 31 selects halfword
// [R24] memory enabled before any use
// [R25] unmapped x-memory access reads zero
// [R26] collision location holds until next collision
`timescale 1ns/1ps
`include "dxwm_defs.vh"

module dxwm_map #(
  parameter [21:0] CORE_BASE   = `DXWM_CORE_BASE,
  parameter [15:0] XDATA_WORDS = 16'h4000,
  parameter        SH_AW       = 12,
  parameter        SH_DEPTH    = 4096
) (
  input  wire              clock,
  input  wire              rst_n,
  // host register port
  input  wire [21:0]       host_addr,
  input  wire [31:0]       host_wdata,
  input  wire              host_wr,
  input  wire              host_rd,
  output wire [31:0]       host_rdata,
  // firmware memory side
  output wire              fw_wr,
  output wire              fw_rd,
  output wire [2:0]        fw_region,
  output wire              fw_prog,
  output wire [20:0]       fw_index,
  output wire [1:0]        fw_part,
  output wire [31:0]       fw_wdata,
  input  wire [31:0]       fw_rdata,
  // dsp x-memory port
  input  wire [15:0]       xm_addr,
  input  wire [23:0]       xm_wdata,
  input  wire              xm_wr,
  input  wire              xm_rd,
  output wire [23:0]       xm_rdata,
  output wire              xm_rvalid,
  // device register fabric
  output wire [21:0]       dev_addr,
  output wire [31:0]       dev_wdata,
  output wire              dev_wide,
  output wire              dev_wr,
  output wire              dev_rd,
  input  wire [31:0]       dev_rdata,
  // shared area ports of dsp2 and dsp3
  input  wire [SH_AW-1:0]  sh2_addr,
  input  wire [23:0]       sh2_wdata,
  input  wire              sh2_wr,
  input  wire              sh2_rd,
  output wire [23:0]       sh2_rdata,
  input  wire [SH_AW-1:0]  sh3_addr,
  input  wire [23:0]       sh3_wdata,
  input  wire              sh3_wr,
  input  wire              sh3_rd,
  output wire [23:0]       sh3_rdata,
  output wire              collision_event
);

  reg  [15:0]      win_page_ff [0:3];
  reg              win_mode_ff [0:3];
  reg  [23:0]      sh_mem      [0:SH_DEPTH-1];
  reg  [SH_AW-1:0] coll_loc_ff;
  reg              coll_event_ff;
  reg  [31:0]      host_rdata_ff;
  reg  [23:0]      sh2_rdata_ff;
  reg  [23:0]      sh3_rdata_ff;
  reg  [21:0]      dev_addr_ff;
  reg  [31:0]      dev_wdata_ff;
  reg              dev_wide_ff;
  reg              dev_wr_ff;
  reg              dev_rd_ff;
  reg              p1_rd_ff;
  reg              p1_hit_ff;
  reg              p1_hw_ff;
  reg              p2_rd_ff;
  reg              p2_hit_ff;
  reg              p2_hw_ff;
  reg  [23:0]      xm_rdata_ff;
  reg              xm_rvalid_ff;

  // host side decode
  reg              fw_hit_c;
  reg  [2:0]       fw_rgn_c;
  reg  [21:0]      fw_ofs_c;
  reg  [43:0]      bnd;
  reg              win_hit_c;
  reg  [1:0]       win_sel_c;
  reg  [21:0]      rel;
  reg  [31:0]      nxt_host_rdata;
  integer          k;
  integer          r;

  wire [21:0] host_even = {host_addr[21:1], 1'b0};
  wire        sh_a_hit  = host_even >= `DXWM_SH_A_BASE && host_even <= `DXWM_SH_A_LAST;
  wire        sh_b_hit  = host_even >= `DXWM_SH_B_BASE && host_even <= `DXWM_SH_B_LAST;
  wire        sh_hit    = sh_a_hit | sh_b_hit;
  wire [21:0] sh_rel    = host_even - (sh_a_hit ? `DXWM_SH_A_BASE : `DXWM_SH_B_BASE);
  // both aliases fold onto one word index
  wire [SH_AW-1:0] sh_idx = sh_rel[SH_AW:1]; // R02
  wire        coll_hit  = host_even == CORE_BASE + `DXWM_COLL_LOC_OFS;

  // regions never overlap, so at most one pass of the decode loop hits
  function [43:0] rgn_bounds;
    input [2:0] i;
    begin
      case (i)
        3'h0:    rgn_bounds = {`DXWM_P1_BASE, `DXWM_P1_LAST}; // R17
        3'h1:    rgn_bounds = {`DXWM_P2_BASE, `DXWM_P2_LAST}; // R18
        3'h2:    rgn_bounds = {`DXWM_P3_BASE, `DXWM_P3_LAST}; // R18
        3'h3:    rgn_bounds = {`DXWM_P4_BASE, `DXWM_P4_LAST}; // R19
        3'h4:    rgn_bounds = {`DXWM_X6_BASE, `DXWM_X6_LAST}; // R20
        3'h5:    rgn_bounds = {`DXWM_X1_BASE, `DXWM_X1_LAST}; // R21
        default: rgn_bounds = {`DXWM_X3_BASE, `DXWM_X3_LAST}; // R22
      endcase
    end
  endfunction

  always @* begin
    fw_hit_c  = 1'b0;
    fw_rgn_c  = 3'h0;
    fw_ofs_c  = 22'h0;
    bnd       = 44'h0;
    win_hit_c = 1'b0;
    win_sel_c = 2'h0;
    rel       = host_even - CORE_BASE - `DXWM_WIN_CTRL_OFS;
    for (k = 0; k < `DXWM_RGN_COUNT; k = k + 1) begin
      bnd = rgn_bounds(k[2:0]);
      if (host_even >= bnd[43:22] && host_even <= bnd[21:0]) begin
        fw_hit_c = 1'b1;
        fw_rgn_c = k[2:0];
        fw_ofs_c = host_even - bnd[43:22];
      end
    end
    if (rel[21:3] == 19'h0) begin
      win_hit_c = 1'b1;
      win_sel_c = rel[2:1];
    end
  end

  // 32-bit register number within the region
  wire [20:0] fw_reg    = fw_ofs_c[21:1];
  wire        prog_rgn  = fw_rgn_c < `DXWM_PROG_RGNS;
  // constant divide by three folds into adders, no real divider
  wire [21:0] pm_pair   = {1'b0, fw_reg} / `DXWM_PM_REGS_PER2; // R05
  wire [21:0] pm_part   = {1'b0, fw_reg} % `DXWM_PM_REGS_PER2; // R05

  // firmware path runs on the system clock only, no dsp clock involved
  assign fw_wr     = host_wr & fw_hit_c; // R01
  assign fw_rd     = host_rd & fw_hit_c; // R01
  assign fw_region = fw_rgn_c;
  assign fw_prog   = fw_hit_c & prog_rgn;
  assign fw_index  = prog_rgn ? pm_pair[20:0] : fw_reg;
  assign fw_part   = prog_rgn ? pm_part[1:0] : 2'h0;
  assign fw_wdata  = host_wdata;

  always @* begin
    nxt_host_rdata = 32'h0;
    if (win_hit_c) begin
      nxt_host_rdata = {win_mode_ff[win_sel_c], 15'h0, win_page_ff[win_sel_c]};
    end else if (coll_hit) begin
      nxt_host_rdata = {{(32-SH_AW){1'b0}}, coll_loc_ff};
    end else if (sh_hit) begin
      nxt_host_rdata = {8'h0, sh_mem[sh_idx]}; // R02
    end else if (fw_hit_c) begin
      nxt_host_rdata = fw_rdata;
    end
  end

  // window control words
  // bits 30:16 are not stored and read back as zero
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (r = 0; r < 4; r = r + 1) begin
        win_page_ff[r] <= `DXWM_WIN_PAGE_RST;
        win_mode_ff[r] <= `DXWM_WIN_MODE_RST;
      end
    end else if (host_wr && win_hit_c) begin
      win_page_ff[win_sel_c] <= host_wdata[15:0]; // R10
      win_mode_ff[win_sel_c] <= host_wdata[`DXWM_WIN_MODE_BIT]; // R23
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      host_rdata_ff <= 32'h0;
    end else if (host_rd) begin
      host_rdata_ff <= nxt_host_rdata;
    end
  end

  // read data hold until the next read strobe
  assign host_rdata = host_rdata_ff;

  // shared area: later assignments win, so dsp3 beats dsp2 beats host
  // no reset: contents stay unknown until written, like a real ram
  always @(posedge clock) begin
    if (host_wr && sh_hit) begin
      sh_mem[sh_idx] <= host_wdata[23:0]; // R02
    end
    if (sh2_wr) begin
      sh_mem[sh2_addr] <= sh2_wdata;
    end
    if (sh3_wr) begin
      sh_mem[sh3_addr] <= sh3_wdata;
    end
  end

  // a host write on the same word is no collision, it just loses
  wire collide = sh2_wr & sh3_wr & (sh2_addr == sh3_addr); // R03

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      coll_loc_ff   <= {SH_AW{1'b0}};
      coll_event_ff <= 1'b0;
      sh2_rdata_ff  <= 24'h0;
      sh3_rdata_ff  <= 24'h0;
    end else begin
      coll_event_ff <= collide; // R04
      if (collide) begin
        // both addresses are equal here
        coll_loc_ff <= sh2_addr; // R26
      end
      if (sh2_rd) begin
        sh2_rdata_ff <= sh_mem[sh2_addr];
      end
      if (sh3_rd) begin
        sh3_rdata_ff <= sh_mem[sh3_addr];
      end
    end
  end

  assign sh2_rdata       = sh2_rdata_ff;
  assign sh3_rdata       = sh3_rdata_ff;
  // one-cycle pulse for the interrupt logic outside this block
  assign collision_event = coll_event_ff;

  // x-memory window decode; window space sits above any core data size
  wire        xm_local = xm_addr < XDATA_WORDS; // R07
  wire        xm_fix   = xm_addr >= `DXWM_FIX_FIRST && xm_addr <= `DXWM_FIX_LAST; // R08
  wire        xm_mov   = xm_addr[15:12] == `DXWM_MOV_NIBBLE; // R09
  wire [1:0]  xm_win   = xm_addr[11:10]; // R09
  wire [9:0]  xm_off   = xm_addr[9:0];
  wire [15:0] sel_page = win_page_ff[xm_win]; // R15
  wire        sel_hw   = win_mode_ff[xm_win];
  wire [24:0] win_base = {sel_page, {`DXWM_PAGE_SHIFT{1'b0}}}; // R14
  wire [24:0] hw_addr  = win_base + {15'h0, xm_off}; // R11
  wire [24:0] wd_addr  = win_base + {14'h0, xm_off, 1'b0}; // R12
  wire [15:0] fix_rel  = xm_addr - `DXWM_FIX_FIRST;
  // upper register space wraps: page bits beyond the fabric are dropped
  wire [21:0] map_addr = xm_fix ? {6'h0, fix_rel} : (sel_hw ? hw_addr[21:0] : wd_addr[21:0]);
  // the fixed window is always halfword
  wire        map_hw   = xm_fix | sel_hw;
  // data-space accesses stay in the core's own ram, never on the fabric
  wire        xm_hit   = !xm_local && (xm_fix || xm_mov); // R06

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dev_addr_ff  <= 22'h0;
      dev_wdata_ff <= 32'h0;
      dev_wide_ff  <= 1'b0;
      dev_wr_ff    <= 1'b0;
      dev_rd_ff    <= 1'b0;
    end else begin
      dev_wr_ff <= xm_wr & xm_hit; // R25
      dev_rd_ff <= xm_rd & xm_hit; // R25
      if ((xm_wr | xm_rd) & xm_hit) begin
        dev_addr_ff  <= map_addr; // R06
        dev_wide_ff  <= !map_hw;
        // wide mode leaves the odd register's top byte at zero
        dev_wdata_ff <= map_hw ? {16'h0, xm_wdata[15:0]} : {8'h0, xm_wdata}; // R13
      end
    end
  end

  assign dev_addr  = dev_addr_ff;
  assign dev_wdata = dev_wdata_ff;
  assign dev_wide  = dev_wide_ff;
  assign dev_wr    = dev_wr_ff;
  assign dev_rd    = dev_rd_ff;

  // read return: issue, fabric answer, then hand back to the core
  // unmapped reads still answer with zero so a core never stalls
  // a fabric slower than one cycle would need a deeper pipe here
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      p1_rd_ff     <= 1'b0;
      p1_hit_ff    <= 1'b0;
      p1_hw_ff     <= 1'b0;
      p2_rd_ff     <= 1'b0;
      p2_hit_ff    <= 1'b0;
      p2_hw_ff     <= 1'b0;
      xm_rdata_ff  <= 24'h0;
      xm_rvalid_ff <= 1'b0;
    end else begin
      p1_rd_ff     <= xm_rd & !xm_local;
      p1_hit_ff    <= xm_hit;
      p1_hw_ff     <= map_hw;
      p2_rd_ff     <= p1_rd_ff;
      p2_hit_ff    <= p1_hit_ff;
      p2_hw_ff     <= p1_hw_ff;
      xm_rvalid_ff <= p2_rd_ff;
      if (p2_rd_ff) begin
        if (!p2_hit_ff) begin
          xm_rdata_ff <= 24'h0; // R25
        end else if (p2_hw_ff) begin
          xm_rdata_ff <= {8'h0, dev_rdata[15:0]}; // R11
        end else begin
          xm_rdata_ff <= dev_rdata[23:0]; // R13
        end
      end
    end
  end

  assign xm_rdata  = xm_rdata_ff;
  assign xm_rvalid = xm_rvalid_ff;

endmodule

// ---- hdl/dxwm_defs.vh ----
// constants for the dsp x-memory register window mapper
// assumes 16-bit register addressing, 22-bit device register addresses
`ifndef DXWM_DEFS_VH
`define DXWM_DEFS_VH

// fixed window in x-memory, maps onto device registers from zero
`define DXWM_FIX_FIRST     16'hc000
`define DXWM_FIX_LAST      16'hdfff
// movable windows a/b/c/d start at f000, f400, f800, fc00
`define DXWM_MOV_NIBBLE    4'hf
`define DXWM_PAGE_SHIFT    9

// window control words and collision location, relative to the core base
`define DXWM_WIN_CTRL_OFS  22'h000054
`define DXWM_COLL_LOC_OFS  22'h000070
`define DXWM_CORE_BASE     22'h0ffe00
`define DXWM_WIN_MODE_BIT  31
`define DXWM_WIN_MODE_RST  1'b0
`define DXWM_WIN_PAGE_RST  16'h0000

// shared dsp2/dsp3 data area, two aliases
`define DXWM_SH_A_BASE     22'h136000
`define DXWM_SH_A_LAST     22'h137ffe
`define DXWM_SH_B_BASE     22'h1b6000
`define DXWM_SH_B_LAST     22'h1b7ffe

// firmware memory regions
`define DXWM_P1_BASE       22'h080000
`define DXWM_P1_LAST       22'h085ffe
`define DXWM_P2_BASE       22'h100000
`define DXWM_P2_LAST       22'h10effe
`define DXWM_P3_BASE       22'h180000
`define DXWM_P3_LAST       22'h18effe
`define DXWM_P4_BASE       22'h200000
`define DXWM_P4_LAST       22'h208ffe
`define DXWM_X6_BASE       22'h320000
`define DXWM_X6_LAST       22'h333ffe
`define DXWM_X1_BASE       22'h0a0000
`define DXWM_X1_LAST       22'h0a7ffe
`define DXWM_X3_BASE       22'h1a0000
`define DXWM_X3_LAST       22'h1b1ffe
`define DXWM_RGN_COUNT     7
`define DXWM_PROG_RGNS     4
`define DXWM_PM_REGS_PER2  22'h000003

`endif

// ---- verification/dxwm_map_asserts.sv ----
// port assertions for the x-memory window mapper
// assumes binding to dxwm_map, which hands on its parameters
`timescale 1ns/1ps
module dxwm_map_asserts #(
  parameter [15:0] XDATA_WORDS = 16'h4000,
  parameter        SH_AW       = 12
) (
  input logic             clock,
  input logic             rst_n,
  input logic [15:0]      xm_addr,
  input logic             xm_wr,
  input logic             xm_rd,
  input logic [23:0]      xm_rdata,
  input logic             xm_rvalid,
  input logic [21:0]      dev_addr,
  input logic             dev_wide,
  input logic             dev_wr,
  input logic             dev_rd,
  input logic [31:0]      dev_rdata,
  input logic [SH_AW-1:0] sh2_addr,
  input logic             sh2_wr,
  input logic [SH_AW-1:0] sh3_addr,
  input logic             sh3_wr,
  input logic             collision_event
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire xm   = xm_wr | xm_rd;
  wire fix  = xm_addr[15:13] == 3'h6;
  wire low  = xm_addr < XDATA_WORDS;
  wire hole = !low && !fix && xm_addr[15:12] != 4'hf;
  wire coll = sh2_wr && sh3_wr && sh2_addr == sh3_addr;
  fixed_window_a: assert property (xm && fix && !low |=> (dev_wr || dev_rd) && !dev_wide
    && dev_addr == {9'h0, $past(xm_addr[12:0])}) else $error("fixed window map wrong");
  data_space_a: assert property (xm && low |=> !dev_wr && !dev_rd)
    else $error("data space access reached fabric");
  read_answer_a: assert property (xm_rd && !low |-> ##3 xm_rvalid)
    else $error("read not answered");
  hole_read_a: assert property (xm_rd && hole |-> ##3 xm_rdata == 24'h0)
    else $error("unmapped read not zero");
  wide_read_a: assert property (dev_rd && dev_wide |-> ##2
    xm_rdata == $past(dev_rdata[23:0])) else $error("wide read data wrong");
  half_read_a: assert property (dev_rd && !dev_wide |-> ##2
    xm_rdata == {8'h0, $past(dev_rdata[15:0])}) else $error("halfword read wrong");
  coll_event_a: assert property (coll |=> collision_event) else $error("collision missed");
  coll_cause_a: assert property (collision_event |-> $past(coll))
    else $error("collision without cause");
  cover property (coll);
  cover property (xm_rd && hole);
  cover property (dev_rd && dev_wide);
endmodule
bind dxwm_map dxwm_map_asserts #(.XDATA_WORDS(XDATA_WORDS), .SH_AW(SH_AW)) chk (.*);

// ---- verification/dxwm_fabric_model.sv ----
// register fabric and firmware memory model beyond the mapper
// assumes dev_rdata is taken a cycle after dev_rd, fw_rdata at once
`timescale 1ns/1ps
module dxwm_fabric_model (
  input  logic        clock,
  input  logic [21:0] dev_addr,
  input  logic [31:0] dev_wdata,
  input  logic        dev_wr,
  input  logic        dev_rd,
  output logic [31:0] dev_rdata,
  input  logic        fw_rd,
  input  logic [2:0]  fw_region,
  input  logic [1:0]  fw_part,
  input  logic [20:0] fw_index,
  output logic [31:0] fw_rdata
);
  // memories behind the fabric are always powered and enabled
  // only 13 address bits are kept; the tests use no aliasing addresses
  logic [31:0] regs [0:8191];
  // data flips outside the answer cycle so a late sample shows up
  always @(posedge clock) begin
    if (dev_wr)
      regs[dev_addr[12:0]] <= dev_wdata;
    dev_rdata <= !dev_rd ? ~dev_rdata : regs[dev_addr[12:0]];
  end
  assign fw_rdata = {fw_rd ? 4'h5 : 4'ha, fw_region, fw_part, fw_index, 2'h0};
endmodule

// ---- verification/testbench.sv ----
// self-checking bench for the x-memory window mapper
// assumes the fabric model stands on the device register side
`timescale 1ns/1ps
`include "dxwm_defs.vh"
module testbench;
  logic        clock, rst_n, host_wr, host_rd, fw_wr, fw_rd, fw_prog, xm_wr, xm_rd;
  logic        xm_rvalid, dev_wide, dev_wr, dev_rd, sh2_wr, sh2_rd, sh3_wr, sh3_rd;
  logic        collision_event;
  logic [1:0]  fw_part, p;
  logic [2:0]  fw_region;
  logic [3:0]  sh2_addr, sh3_addr;
  logic [15:0] xm_addr;
  logic [20:0] fw_index;
  logic [21:0] host_addr, dev_addr, a;
  logic [23:0] xm_wdata, xm_rdata, sh2_wdata, sh2_rdata, sh3_wdata, sh3_rdata, d;
  logic [31:0] host_wdata, host_rdata, fw_wdata, fw_rdata, dev_wdata, dev_rdata;
  int          err_count, check_count, cyc, n, i;
  logic [21:0] bas [7] = '{22'h080000, 22'h100000, 22'h180000, 22'h200000,
                           22'h320000, 22'h0a0000, 22'h1a0000};
  int          wd [7] = '{8192, 20480, 20480, 12288, 40960, 16384, 36864};
  logic [15:0] pg [4] = '{16'h0003, 16'h0003, 16'h0001, 16'h1fff};
  logic        hm [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
  localparam logic [21:0] CTL = `DXWM_CORE_BASE + 22'h54;
  localparam logic [21:0] LOC = `DXWM_CORE_BASE + `DXWM_COLL_LOC_OFS;
  dxwm_map #(.SH_AW(4), .SH_DEPTH(16)) dut (.*);
  dxwm_fabric_model fab (.*);
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc > 2000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic hb(input logic w, input logic [21:0] ad, input logic [31:0] v);
    host_addr <= ad;
    host_wdata <= v;
    {host_wr, host_rd} <= {w, !w};
    @(posedge clock);
    {host_wr, host_rd} <= 2'b00;
    #1 if (!w) check(host_rdata, v);
    @(posedge clock);
  endtask
  // a read waits for the three-cycle answer, a write for the fabric strobe
  task automatic xb(input logic w, input logic [15:0] ad, input logic [23:0] v,
                    input logic [31:0] e1, e2);
    xm_addr <= ad;
    xm_wdata <= v;
    {xm_wr, xm_rd} <= {w, !w};
    @(posedge clock);
    {xm_wr, xm_rd} <= 2'b00;
    if (!w) repeat (2) @(posedge clock);
    #1 check(w ? {dev_wr, dev_wide, dev_addr} : {xm_rvalid, xm_rdata}, e1);
    if (w) check(dev_wdata, e2);
    @(posedge clock);
  endtask
  task automatic sb(input logic [3:0] a2, a3);
    {sh2_addr, sh3_addr} <= {a2, a3};
    {sh2_wdata, sh3_wdata} <= {24'h111111, 24'h333333};
    {sh2_wr, sh3_wr} <= 2'b11;
    @(posedge clock);
    {sh2_wr, sh3_wr} <= 2'b00;
    #1 check(collision_event, a2 == a3);
    @(posedge clock);
  endtask
  initial begin
    {host_wr, host_rd, xm_wr, xm_rd, sh2_wr, sh2_rd, sh3_wr, sh3_rd, rst_n} = '0;
    {host_addr, host_wdata, xm_addr, xm_wdata} = '0;
    {sh2_addr, sh3_addr, sh2_wdata, sh3_wdata} = '0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    for (int w = 0; w < 4; w++)
      hb(1'b0, CTL + 22'(2 * w), 32'h0);
    hb(1'b0, LOC, 32'h0);
    fab.regs[22'h200] = 32'hff123456;
    xb(1'b0, 16'hf100, 24'h0, {1'b1, 24'h123456}, 32'h0);
    xb(1'b0, 16'h0100, 24'h0, {1'b0, 24'h123456}, 32'h0);
    xb(1'b1, 16'hc000, 24'h00beef, {2'b10, 22'h0}, 32'hbeef);
    xb(1'b1, 16'hdfff, 24'h12cafe, {2'b10, 22'h1fff}, 32'hcafe);
    xb(1'b0, 16'hdfff, 24'h0, {1'b1, 24'h00cafe}, 32'h0);
    xb(1'b0, 16'he000, 24'h0, {1'b1, 24'h0}, 32'h0);
    for (int w = 0; w < 4; w++)
      hb(1'b1, CTL + 22'(2 * w), {hm[w], 15'h0, pg[w]});
    // b overlaps a, d wraps past the top of the register space
    for (int w = 0; w < 4; w++) begin
      hb(1'b0, CTL + 22'(2 * w), {hm[w], 15'h0, pg[w]});
      a = {pg[w], 9'h0} + (hm[w] ? 22'h3ff : 22'h7fe);
      d = 24'ha5c300 + 24'(w);
      xb(1'b1, 16'hf3ff + 16'(w * 1024), d, {1'b1, !hm[w], a},
         hm[w] ? {16'h0, d[15:0]} : {8'h0, d});
      xb(1'b0, 16'hf3ff + 16'(w * 1024), 24'h0,
         {1'b1, hm[w] ? {8'h0, d[15:0]} : d}, 32'h0);
    end
    for (int k = 0; k < 7; k++) begin
      n = k < 4 ? wd[k] * 3 / 2 : wd[k];
      i = k < 4 ? wd[k] / 2 - 1 : wd[k] - 1;
      p = k < 4 ? 2'h2 : 2'h0;
      host_addr <= bas[k] + 22'(2 * n - 2);
      host_rd <= 1'b1;
      #1 check({fw_rd, fw_prog, fw_region, fw_part, fw_index},
               {1'b1, k < 4, 3'(k), p, 21'(i)});
      @(posedge clock);
      host_addr <= bas[k] + 22'(2 * n);
      #1 check(host_rdata, {4'h5, 3'(k), p, 21'(i), 2'h0});
      check(fw_rd, 1'b0);
      @(posedge clock);
      host_rd <= 1'b0;
      #1 check(host_rdata, 32'h0);
      @(posedge clock);
    end
    // a firmware write is steered at once, with no dsp clock involved
    host_addr <= 22'h100004;
    host_wdata <= 32'h0badf00d;
    host_wr <= 1'b1;
    #1 check({fw_wr, fw_rd, fw_prog, fw_region, fw_part, fw_index},
             {3'h5, 3'h1, 2'h2, 21'h0});
    check(fw_wdata, 32'h0badf00d);
    @(posedge clock);
    host_wr <= 1'b0;
    @(posedge clock);
    sb(4'h5, 4'h5);
    hb(1'b0, LOC, 32'h5);
    hb(1'b0, 22'h13600a, 32'h333333);
    hb(1'b1, 22'h1b600e, 32'habcdef);
    hb(1'b0, 22'h13600e, 32'habcdef);
    sb(4'h9, 4'h9);
    sb(4'h2, 4'h3);
    hb(1'b0, LOC, 32'h9);
    {sh2_addr, sh3_addr} <= {4'h7, 4'h5};
    {sh2_rd, sh3_rd} <= 2'b11;
    @(posedge clock);
    {sh2_rd, sh3_rd} <= 2'b00;
    #1 check(sh2_rdata, 32'habcdef);
    check(sh3_rdata, 32'h333333);
    // mid-run reset clears the location and the window controls
    rst_n <= 1'b0;
    @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    hb(1'b0, LOC, 32'h0);
    hb(1'b0, CTL + 22'h6, 32'h0);
    print_verdict();
  end
endmodule
